// [core/i2c_byte_shifter.sv]
// Byte shift register between the data buffer and the serial data line
`timescale 1ns/1ps
module i2c_byte_shifter
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       load,
  input  wire logic [7:0] loadByte,
  input  wire logic       rxStart,
  input  wire logic       sclRise,
  input  wire logic       sclFall,
  input  wire logic       sdaBit,
  output logic            busy,
  output logic            rxMode,
  output logic            done,
  output logic [7:0]      shiftData,
  output logic            sdaDriveLow
);

  logic [3:0] bitsLeft;

  // Transmit shifts on clock fall, receive samples on clock rise
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      shiftData <= 8'h00;
      bitsLeft  <= 4'h0;
      busy      <= 1'b0;
      rxMode    <= 1'b0;
      done      <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (load)
      begin
        shiftData <= loadByte;
        bitsLeft  <= i2c_data_status_pkg::BITS_PER_BYTE;
        busy      <= 1'b1;
        rxMode    <= 1'b0;
      end
      else if (rxStart)
      begin
        bitsLeft <= i2c_data_status_pkg::BITS_PER_BYTE;
        busy     <= 1'b1;
        rxMode   <= 1'b1;
      end
      else if (busy && ((rxMode && sclRise) || (!rxMode && sclFall)))
      begin
        shiftData <= {shiftData[6:0], rxMode ? sdaBit : 1'b0};
        bitsLeft  <= bitsLeft - 4'h1;
        if (bitsLeft == 4'h1)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  // Open-drain drive: pull low only for a zero bit while transmitting
  always_ff @(posedge clk)
  begin
    if (srst)
      sdaDriveLow <= 1'b0;
    else if (load)
      sdaDriveLow <= ~loadByte[7];
    else if (busy && !rxMode && sclFall && bitsLeft != 4'h1)
      sdaDriveLow <= ~shiftData[6];
    else if (!busy || rxMode || (sclFall && bitsLeft == 4'h1))
      sdaDriveLow <= 1'b0;
  end

endmodule

// [core/i2c_data_status_pkg.sv]
// Shared constants and carrier types for the I2C data and status block
package i2c_data_status_pkg;

  // Register addresses on the 12-bit register port
  localparam logic [11:0] DATA_BUFFER_ADDR  = 12'hf50;
  localparam logic [11:0] STATUS_FLAGS_ADDR = 12'hf51;
  localparam logic [11:0] CONTROL_ADDR      = 12'hf52;
  localparam logic [11:0] EVENT_ADDR        = 12'hf53;
  localparam logic [11:0] MASK_ADDR         = 12'hf54;

  // Reset values
  localparam logic [7:0] DATA_BUFFER_RESET  = 8'h00;
  localparam logic [7:0] STATUS_FLAGS_RESET = 8'h80;
  localparam logic [7:0] CONTROL_RESET      = 8'h00;
  localparam logic [1:0] EVENT_RESET        = 2'h0;
  localparam logic [1:0] MASK_RESET         = 2'h0;

  // Field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int EVT_TX_BIT      = 0;
  localparam int EVT_RX_BIT      = 1;

  // Bits per byte on the wire
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Engine-reported status bits, in register order from bit 5 down to bit 0
  typedef struct packed {
    logic ack;
    logic tenBitAddrFlag;
    logic readDir;
    logic slaveAddrMatchFlag;
    logic busStateFlag;
    logic nackInterruptFlag;
  } engine_status_type;

  // Full status register layout
  typedef struct packed {
    logic              txBufferEmptyFlag;
    logic              rxBufferFullFlag;
    engine_status_type engine;
  } status_flags_type;

  // Register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wrData;
    logic        wr;
    logic        rd;
  } reg_req_type;

endpackage

// [core/i2c_data_status_regs.sv]
// I2C data buffer, status flags, interrupt and byte shifting top level
// How it works
// - A byte written to the data buffer is the next byte loaded for transmit.
// - Each received byte in the shifter is copied into the data buffer.
// - The shift register has no address; software sees bytes only via the buffer.
// - Status is read-only; after reset transmit-empty reads 1, others 0.
// - While enabled, transmit-empty is 1 whenever no byte is pending.
// - Transmit-empty interrupts, except during receive or read-address shifting.
// - Writing the data buffer clears transmit-empty and its pending interrupt.
// - Receive-full is active high and sets only while enabled.
`timescale 1ns/1ps
module i2c_data_status_regs
(
  input  wire logic                                   clk,
  input  wire logic                                   srst,
  input  wire i2c_data_status_pkg::reg_req_type       regReq,
  output logic [7:0]                                  regRdData,
  output logic                                        irq,
  input  wire logic                                   sclIn,
  input  wire logic                                   sdaIn,
  output logic                                        sdaOut,
  output logic                                        sdaOe,
  input  wire logic                                   engTxLoad,
  input  wire logic                                   engRxStart,
  input  wire logic                                   engAddrRead,
  input  wire i2c_data_status_pkg::engine_status_type engStatus,
  output logic                                        shiftBusy,
  output logic                                        byteDone
);

  logic [7:0]                             dataBuf;
  logic                                   pending;
  logic                                   txEmpty;
  logic                                   rxFull;
  logic [7:0]                             control;
  logic [1:0]                             events;
  logic [1:0]                             mask;
  i2c_data_status_pkg::engine_status_type engReg;
  logic [1:0]                             lineSync;
  logic                                   sclRise;
  logic                                   sclFall;
  logic                                   busy;
  logic                                   rxMode;
  logic                                   done;
  logic [7:0]                             shiftData;
  logic                                   sdaDriveLow;
  logic                                   enabled;
  logic                                   dataWr;
  logic                                   dataRd;
  logic                                   eventWr;
  logic                                   loadTake;
  logic [7:0]                             loadByte;
  logic                                   rxLand;
  logic                                   txIrqCond;
  i2c_data_status_pkg::status_flags_type  statusView;

  // Address decode of the register port
  always_comb
  begin
    dataWr  = 1'b0;
    dataRd  = 1'b0;
    eventWr = 1'b0;
    if (regReq.addr == i2c_data_status_pkg::DATA_BUFFER_ADDR)
    begin
      dataWr = regReq.wr;
      dataRd = regReq.rd;
    end
    else if (regReq.addr == i2c_data_status_pkg::EVENT_ADDR)
      eventWr = regReq.wr;
  end

  // Controller enable gates loads, receive starts and the setting of both flags
  assign enabled = control[i2c_data_status_pkg::CTRL_ENABLE_BIT];
  // A write in the load cycle passes straight through, so no byte is lost
  assign loadTake = engTxLoad && enabled && (pending || dataWr);
  assign loadByte = dataWr ? regReq.wrData : dataBuf;
  // A received byte lands only when a receive finishes, never on a transmit
  assign rxLand   = done && rxMode;
  // Receive shifting and read-direction address shifting hold the interrupt off
  assign txIrqCond = txEmpty && enabled && !(busy && rxMode) && !engAddrRead;

  // Synchronisers and edge finder for the bus lines
  i2c_link_sync u_sync
  (
    .clk      (clk),
    .srst     (srst),
    .lineIn   ({sdaIn, sclIn}),
    .lineSync (lineSync),
    .sclRise  (sclRise),
    .sclFall  (sclFall)
  );

  // Shift register, reachable only through the data buffer
  i2c_byte_shifter u_shift
  (
    .clk         (clk),
    .srst        (srst),
    .load        (loadTake),
    .loadByte    (loadByte),
    .rxStart     (engRxStart && enabled && !loadTake),
    .sclRise     (sclRise),
    .sclFall     (sclFall),
    .sdaBit      (lineSync[1]),
    .busy        (busy),
    .rxMode      (rxMode),
    .done        (done),
    .shiftData   (shiftData),
    .sdaDriveLow (sdaDriveLow)
  );

  // Data buffer: software writes, received bytes overwrite
  always_ff @(posedge clk)
  begin
    if (srst)
      dataBuf <= i2c_data_status_pkg::DATA_BUFFER_RESET;
    else if (rxLand)
      dataBuf <= shiftData;
    else if (dataWr)
      dataBuf <= regReq.wrData;
  end

  // Pending byte tracking; a load empties the buffer
  always_ff @(posedge clk)
  begin
    if (srst)
      pending <= 1'b0;
    else if (loadTake)
      pending <= 1'b0;
    else if (dataWr)
      pending <= 1'b1;
  end

  // Transmit-empty: load sets and wins over the clearing write
  always_ff @(posedge clk)
  begin
    if (srst)
      txEmpty <= i2c_data_status_pkg::STATUS_FLAGS_RESET[7];
    else if (loadTake || (enabled && !pending && !dataWr))
      txEmpty <= 1'b1;
    else if (dataWr)
      txEmpty <= 1'b0;
  end

  // Receive-full: landing byte sets and wins over the clearing read
  always_ff @(posedge clk)
  begin
    if (srst)
      rxFull <= i2c_data_status_pkg::STATUS_FLAGS_RESET[6];
    else if (rxLand && enabled)
      rxFull <= 1'b1;
    else if (dataRd)
      rxFull <= 1'b0;
  end

  // Control and mask registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      control <= i2c_data_status_pkg::CONTROL_RESET;
      mask    <= i2c_data_status_pkg::MASK_RESET;
    end
    else if (regReq.wr && regReq.addr == i2c_data_status_pkg::CONTROL_ADDR)
      control <= regReq.wrData;
    else if (regReq.wr && regReq.addr == i2c_data_status_pkg::MASK_ADDR)
      mask <= regReq.wrData[1:0];
  end

  // Sticky events: set wins over write-one-to-clear; the buffer write clears the transmit event and wins over its set
  always_ff @(posedge clk)
  begin
    if (srst)
      events <= i2c_data_status_pkg::EVENT_RESET;
    else
    begin
      if (txIrqCond && !dataWr)
        events[i2c_data_status_pkg::EVT_TX_BIT] <= 1'b1;
      else if (dataWr || (eventWr && regReq.wrData[i2c_data_status_pkg::EVT_TX_BIT]))
        events[i2c_data_status_pkg::EVT_TX_BIT] <= 1'b0;
      if (rxLand && enabled)
        events[i2c_data_status_pkg::EVT_RX_BIT] <= 1'b1;
      else if (eventWr && regReq.wrData[i2c_data_status_pkg::EVT_RX_BIT])
        events[i2c_data_status_pkg::EVT_RX_BIT] <= 1'b0;
    end
  end

  // Interrupt level, registered so the output comes from a flop
  always_ff @(posedge clk)
  begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= |(events & mask);
  end

  // Engine status snapshot, zero after reset
  always_ff @(posedge clk)
  begin
    if (srst)
      engReg <= '0;
    else
      engReg <= engStatus;
  end

  // Buffer flags sit above the engine snapshot in the status byte
  assign statusView = {txEmpty, rxFull, engReg};

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk)
  begin
    if (srst)
      regRdData <= 8'h00;
    else if (!regReq.rd)
      regRdData <= 8'h00;
    else if (regReq.addr == i2c_data_status_pkg::DATA_BUFFER_ADDR)
      regRdData <= dataBuf;
    else if (regReq.addr == i2c_data_status_pkg::STATUS_FLAGS_ADDR)
      regRdData <= statusView;
    else if (regReq.addr == i2c_data_status_pkg::CONTROL_ADDR)
      regRdData <= control;
    else if (regReq.addr == i2c_data_status_pkg::EVENT_ADDR)
      regRdData <= {6'h00, events};
    else if (regReq.addr == i2c_data_status_pkg::MASK_ADDR)
      regRdData <= {6'h00, mask};
    else
      regRdData <= 8'h00;
  end

  // Pin and engine-facing outputs from flops
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sdaOut    <= 1'b0;
      sdaOe     <= 1'b0;
      shiftBusy <= 1'b0;
      byteDone  <= 1'b0;
    end
    else
    begin
      sdaOut    <= 1'b0;
      sdaOe     <= sdaDriveLow;
      shiftBusy <= busy;
      byteDone  <= done;
    end
  end

  // Every check samples on the rising clock and rests while reset is high
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Shifter, buffer and read-port checks
  AST_LOAD_BYTE: assert property (loadTake && !dataWr |=> shiftData == $past(dataBuf))
    else $error("load did not take the buffered byte");
  AST_FIRST_BIT: assert property (loadTake |=> sdaDriveLow == !$past(loadByte[7]))
    else $error("first transmit bit not driven");
  AST_PENDING_SET: assert property (dataWr && !loadTake |=> pending)
    else $error("written byte not held for transmit");
  AST_RX_COPY: assert property (rxLand |=> dataBuf == $past(shiftData))
    else $error("received byte not copied to buffer");
  AST_RX_RELEASED: assert property (busy && rxMode && !loadTake |=> !sdaDriveLow)
    else $error("data line driven while receiving");
  AST_BYTE_DONE: assert property (done |=> byteDone && !shiftBusy)
    else $error("byte completion not reported");
  AST_DATA_READ: assert property (dataRd |=> regRdData == $past(dataBuf))
    else $error("buffer read returned wrong byte");
  AST_UNMAPPED_ZERO: assert property (
    regReq.rd && regReq.addr > i2c_data_status_pkg::MASK_ADDR |=> regRdData == 8'h00)
    else $error("unmapped read returned nonzero");
  AST_RD_IDLE_ZERO: assert property (!regReq.rd |=> regRdData == 8'h00)
    else $error("read data not zero outside a read");
  AST_RESET_STATUS: assert property ($past(srst) |-> txEmpty && !rxFull && engReg == '0)
    else $error("status not at reset value");
  AST_STATUS_READ: assert property (
    regReq.rd && regReq.addr == i2c_data_status_pkg::STATUS_FLAGS_ADDR
    |=> regRdData == $past(statusView))
    else $error("status read returned wrong flags");

  // Flag and interrupt checks
  AST_EMPTY_LEVEL: assert property (enabled && !pending && !dataWr |=> txEmpty)
    else $error("empty buffer without transmit-empty");
  AST_EMPTY_AFTER_LOAD: assert property (loadTake |=> txEmpty)
    else $error("load left transmit-empty low");
  AST_TX_IRQ: assert property (
    txIrqCond && !dataWr && mask[0]
    && !(regReq.wr && regReq.addr == i2c_data_status_pkg::MASK_ADDR) |-> ##2 irq)
    else $error("transmit-empty interrupt missing");
  AST_RX_NO_TX_EVENT: assert property (busy && rxMode && !events[0] |=> !events[0])
    else $error("transmit event set during receive");
  AST_ADDR_NO_TX_EVENT: assert property (engAddrRead && !events[0] |=> !events[0])
    else $error("transmit event set during read address");
  AST_WRITE_CLEARS: assert property (
    dataWr && !loadTake && !(enabled && engTxLoad) |=> !txEmpty && !events[0])
    else $error("buffer write did not clear transmit-empty");
  AST_RX_ENABLED: assert property ($rose(rxFull) |-> $past(enabled))
    else $error("receive-full set while disabled");
  AST_DISABLED_NO_RX: assert property (!enabled && !rxFull |=> !rxFull)
    else $error("receive-full rose with controller off");
  AST_RX_READ_CLEARS: assert property (dataRd && !rxLand |=> !rxFull)
    else $error("buffer read did not clear receive-full");
  AST_RX_SETS: assert property (rxLand && enabled |=> rxFull [*1] ##0 events[1])
    else $error("landed byte did not set receive-full");

endmodule

// [core/i2c_link_sync.sv]
// Two-flop synchronisers for the bus lines and clock-edge finder
`timescale 1ns/1ps
module i2c_link_sync
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [1:0] lineIn,
  output logic      [1:0] lineSync,
  output logic            sclRise,
  output logic            sclFall
);

  logic [1:0] stage1;
  logic       sclLast;

  // One synchroniser per line; stage1 feeds only the second flop
  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          stage1[i]   <= 1'b1;
          lineSync[i] <= 1'b1;
        end
        else
        begin
          stage1[i]   <= lineIn[i];
          lineSync[i] <= stage1[i];
        end
      end
    end
  endgenerate

  // Edge finder on the synchronised clock line (bit 0)
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sclLast <= 1'b1;
      sclRise <= 1'b0;
      sclFall <= 1'b0;
    end
    else
    begin
      sclLast <= lineSync[0];
      sclRise <= lineSync[0] & ~sclLast;
      sclFall <= ~lineSync[0] & sclLast;
    end
  end

endmodule

// [tb/i2c_slave_model.sv]
// Far-side partner that clocks the link and sends or captures one byte
`timescale 1ns/1ps
module i2c_slave_model
(
  input  wire logic sdaLine,
  output logic      scl,
  output logic      slaveLow
);
  // Clock stands still low between bytes, so no stray fall shifts a loaded byte
  initial
  begin
    scl      = 1'b0;
    slaveLow = 1'b0;
  end

  // MSB first; data moves only while the clock is low, sampled late in the high phase
  task automatic run_byte(input logic [7:0] send, input int lowNs, output logic [7:0] got);
    for (int i = 7; i >= 0; i--)
    begin
      slaveLow = ~send[i];
      #(lowNs);
      scl = 1'b1;
      #30;
      got[i] = sdaLine;
      #10;
      scl = 1'b0;
    end
    slaveLow = 1'b0; // Released line floats back to the pull-up level
  endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the I2C data and status block
`timescale 1ns/1ps
`define CHECK(got, exp) \
  begin \
    samplesChecked++; \
    if ((got) !== (exp)) \
    begin \
      errorCnt++; \
      $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
    end \
  end
module testbench;
  logic                                   clk = 1'b0;
  logic                                   srst = 1'b1;
  i2c_data_status_pkg::reg_req_type       regReq = '0;
  logic [7:0]                             regRdData;
  logic                                   irq;
  logic                                   sclIn;
  logic                                   sdaOut;
  logic                                   sdaOe;
  logic                                   slaveLow;
  logic                                   engTxLoad = 1'b0;
  logic                                   engRxStart = 1'b0;
  logic                                   engAddrRead = 1'b0;
  i2c_data_status_pkg::engine_status_type engStatus = '0;
  logic                                   shiftBusy;
  logic                                   byteDone;
  logic [7:0]                             got;
  int                                     errorCnt = 0;
  int                                     samplesChecked = 0;
  wire                                    sdaLine = (sdaOe ? sdaOut : 1'b1) & ~slaveLow;

  // 100 MHz clock
  always #5 clk = ~clk;

  i2c_data_status_regs i_dut
  (
    .clk         (clk),
    .srst        (srst),
    .regReq      (regReq),
    .regRdData   (regRdData),
    .irq         (irq),
    .sclIn       (sclIn),
    .sdaIn       (sdaLine),
    .sdaOut      (sdaOut),
    .sdaOe       (sdaOe),
    .engTxLoad   (engTxLoad),
    .engRxStart  (engRxStart),
    .engAddrRead (engAddrRead),
    .engStatus   (engStatus),
    .shiftBusy   (shiftBusy),
    .byteDone    (byteDone)
  );

  i2c_slave_model i_slave
  (
    .sdaLine  (sdaLine),
    .scl      (sclIn),
    .slaveLow (slaveLow)
  );

  // Register port accesses: one-cycle strobes, read data in the following cycle
  task automatic wrReg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    regReq.wr <= 1'b0;
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    regReq <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regReq.rd <= 1'b0;
    #1;
    `CHECK(regRdData, exp)
  endtask

  task automatic irqChk(input logic exp, input int cycles);
    repeat (cycles) @(posedge clk);
    #1;
    `CHECK(irq, exp)
  endtask

  // One-cycle engine request, transmit load or receive start
  task automatic kick(input logic tx);
    @(posedge clk);
    engTxLoad  <= tx;
    engRxStart <= ~tx;
    @(posedge clk);
    engTxLoad  <= 1'b0;
    engRxStart <= 1'b0;
  endtask

  // Bounded wait, a hang counts as a mismatch
  task automatic waitDone();
    int n;
    n = 0;
    while (byteDone !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 100)
      begin
        errorCnt++;
        testDone();
      end
    end
  endtask

  task automatic testDone();
    $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rdChk(i2c_data_status_pkg::STATUS_FLAGS_ADDR, 8'h80);
    rdChk(i2c_data_status_pkg::DATA_BUFFER_ADDR, 8'h00);
    wrReg(i2c_data_status_pkg::STATUS_FLAGS_ADDR, 8'h00);
    rdChk(i2c_data_status_pkg::STATUS_FLAGS_ADDR, 8'h80);
    wrReg(12'hf55, 8'hff);
    rdChk(12'hf55, 8'h00);
    rdChk(i2c_data_status_pkg::DATA_BUFFER_ADDR, 8'h00);
    $display("test reset done");
    // Enable with the interrupt masked, then unmask
    @(posedge clk);
    engStatus <= 6'h15;
    wrReg(i2c_data_status_pkg::CONTROL_ADDR, 8'h01);
    irqChk(1'b0, 3);
    rdChk(i2c_data_status_pkg::EVENT_ADDR, 8'h01);
    rdChk(i2c_data_status_pkg::STATUS_FLAGS_ADDR, 8'h95);
    wrReg(i2c_data_status_pkg::MASK_ADDR, 8'h03);
    irqChk(1'b1, 2);
    $display("test interrupt done");
    // Transmit a byte
    wrReg(i2c_data_status_pkg::DATA_BUFFER_ADDR, 8'ha5);
    irqChk(1'b0, 2);
    rdChk(i2c_data_status_pkg::STATUS_FLAGS_ADDR, 8'h15);
    kick(1'b1);
    @(posedge clk);
    #1;
    `CHECK(shiftBusy, 1'b1)
    i_slave.run_byte(8'hff, 40, got);
    `CHECK(got, 8'ha5)
    `CHECK(sdaOut, 1'b0)
    waitDone();
    `CHECK(shiftBusy, 1'b0)
    rdChk(i2c_data_status_pkg::STATUS_FLAGS_ADDR, 8'h95);
    irqChk(1'b1, 1);
    $display("test transmit done");
    // Address with read direction holds the transmit interrupt off
    @(posedge clk);
    engAddrRead <= 1'b1;
    wrReg(i2c_data_status_pkg::EVENT_ADDR, 8'h01);
    irqChk(1'b0, 2);
    @(posedge clk);
    engAddrRead <= 1'b0;
    irqChk(1'b1, 3);
    $display("test address read done");
    // Receive a byte at the same link clock period
    kick(1'b0);
    wrReg(i2c_data_status_pkg::EVENT_ADDR, 8'h01);
    irqChk(1'b0, 2);
    i_slave.run_byte(8'h3c, 40, got);
    waitDone();
    rdChk(i2c_data_status_pkg::STATUS_FLAGS_ADDR, 8'hd5);
    rdChk(i2c_data_status_pkg::DATA_BUFFER_ADDR, 8'h3c);
    rdChk(i2c_data_status_pkg::STATUS_FLAGS_ADDR, 8'h95);
    rdChk(i2c_data_status_pkg::EVENT_ADDR, 8'h03);
    wrReg(i2c_data_status_pkg::EVENT_ADDR, 8'h02);
    $display("test receive done");
    // Disabled controller ignores a received byte
    wrReg(i2c_data_status_pkg::CONTROL_ADDR, 8'h00);
    wrReg(i2c_data_status_pkg::EVENT_ADDR, 8'h03);
    irqChk(1'b0, 2);
    kick(1'b0);
    i_slave.run_byte(8'h77, 40, got);
    repeat (8) @(posedge clk);
    rdChk(i2c_data_status_pkg::STATUS_FLAGS_ADDR, 8'h95);
    rdChk(i2c_data_status_pkg::DATA_BUFFER_ADDR, 8'h3c);
    $display("test disabled done");
    testDone();
  end
endmodule
